/* hw/ppfm_pinsel.sv */
// Per-pin function multiplexer with registered pin and input drives.
// Assumes pin levels are synchronous to sys_clk.
`timescale 1ns/1ps
module ppfm_pinsel import ppfm_pkg::*; (
    input wire logic sys_clk, // System clock
    input wire logic reset, // Async reset, active high
    input wire logic [7:0] funcSel, // Alternate function selects
    input wire logic [7:0] direction, // General I/O directions
    input wire logic [7:0] dataLatch, // General I/O output latch
    input wire logic [7:0] altOut, // Peripheral output levels
    input wire logic [7:0] altOe, // Peripheral drive requests
    input wire logic [7:0] pinIn, // Pin levels
    output logic [7:0] pinOut, // Registered pin output level
    output logic [7:0] pinOe, // Registered pin output enable
    output logic [7:0] altIn // Registered peripheral inputs
);

    logic [7:0] out_q;
    logic [7:0] oe_q;
    logic [7:0] in_q;

    assign pinOut = out_q;
    assign pinOe = oe_q;
    assign altIn = in_q;

    // --------------------------------------------------------------
    // Pin slices
    // --------------------------------------------------------------
    genvar i;
    generate
        for (i = 0; i < 8; i++) begin : g_pin
            // Select ignores direction bit; pins float during reset
            always_ff @(posedge sys_clk or posedge reset) begin
                if (reset) begin
                    out_q[i] <= 1'b0;
                    oe_q[i] <= 1'b0;
                    in_q[i] <= 1'b1;
                end else if (funcSel[i]) begin
                    out_q[i] <= altOut[i];
                    oe_q[i] <= altOe[i];
                    in_q[i] <= pinIn[i];
                end else begin
                    out_q[i] <= dataLatch[i];
                    oe_q[i] <= direction[i];
                    in_q[i] <= ALT_IN_IDLE[i];
                end
            end
        end
    endgenerate

endmodule // ppfm_pinsel

/* hw/ppfm_pkg.sv */
// Constants and carrier types for the port 3 pin function multiplexer.
// Assumes a 32-bit classic Wishbone slave port with byte addressing.
package ppfm_pkg;

    // ----------------------------------------------------------------
    // Register map (byte addresses, one aligned word each)
    // ----------------------------------------------------------------
    localparam logic [7:0] OFS_DATA_LATCH = 8'h00;
    localparam logic [7:0] OFS_DIRECTION = 8'h04;
    localparam logic [7:0] OFS_PULLUP = 8'h08;
    localparam logic [7:0] OFS_FUNC_SEL = 8'h0c;
    localparam logic [1:0] IDX_DATA_LATCH = 2'h0;
    localparam logic [1:0] IDX_DIRECTION = 2'h1;
    localparam logic [1:0] IDX_PULLUP = 2'h2;
    localparam logic [1:0] IDX_FUNC_SEL = 2'h3;

    // ----------------------------------------------------------------
    // Reset and fixed read values
    // ----------------------------------------------------------------
    localparam logic [7:0] RST_DATA_LATCH = 8'h00;
    localparam logic [7:0] RST_DIRECTION = 8'h00;
    localparam logic [7:0] RST_PULLUP = 8'h00;
    localparam logic [7:0] RST_FUNC_SEL = 8'h00;
    localparam logic [7:0] DIR_READ_VALUE = 8'hff;
    localparam logic [7:0] ALT_IN_IDLE = 8'hff;

    // ----------------------------------------------------------------
    // Function select bit positions
    // ----------------------------------------------------------------
    localparam int BIT_CHIP_SEL = 7;
    localparam int BIT_STROBE = 6;
    localparam int BIT_SB_DOUT = 5;
    localparam int BIT_SB_DIN = 4;
    localparam int BIT_SB_CLK = 3;
    localparam int BIT_SA_DOUT = 2;
    localparam int BIT_SA_DIN = 1;
    localparam int BIT_SA_CLK = 0;

    // Serial B clock source code that means an external clock
    localparam logic [2:0] SB_CLK_EXTERNAL = 3'h7;

    // ----------------------------------------------------------------
    // Bus request carrier
    // ----------------------------------------------------------------
    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [7:0] adr;
        logic [3:0] sel;
        logic [31:0] dat;
    } ppfm_wb_req_s;

endpackage

/* hw/ppfm_top.sv */
// Port 3 pin function multiplexer: registers, routing and checks.
// Assumes serial units and strobe logic sit on the same sys_clk.
`timescale 1ns/1ps
module ppfm_top import ppfm_pkg::*; (
    input wire logic sys_clk, // System clock, 40 MHz
    input wire logic reset, // Async reset, active high
    input wire ppfm_wb_req_s wbReq, // Wishbone request
    output logic wbAck, // Wishbone acknowledge
    output logic [31:0] wbDatOut, // Wishbone read data
    input wire logic [7:0] generalPortPinIn, // Pin levels
    output logic [7:0] generalPortPinOut, // Pin output levels
    output logic [7:0] generalPortPinOe, // Pin output enables
    output logic [7:0] pullupEn, // Pull-up enables
    output logic chipSelectInN, // Chip select to peripheral
    input wire logic strobeOutput, // Strobe from peripheral
    input wire logic serialBDataOut, // Serial B transmit data
    output logic serialBDataIn, // Serial B receive data
    input wire logic serialBClockOut, // Serial B internal clock
    output logic serialBClockIn, // Serial B external clock
    input wire logic [2:0] serialBClockSourceField, // B clock source
    input wire logic serialADataOut, // Serial A transmit data
    output logic serialADataIn, // Serial A receive data
    input wire logic serialAClockOut, // Serial A internal clock
    output logic serialAClockIn, // Serial A external clock
    input wire logic serialAClockExternal // A expects external clock
);

    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    logic [7:0] funcSel_q;
    logic [7:0] direction_q;
    logic [7:0] dataLatch_q;
    logic [7:0] pullup_q;
    logic [7:0] pullupEn_q;
    logic [7:0] portRead;
    logic [7:0] altOut;
    logic [7:0] altOe;
    logic [7:0] altIn;
    logic [31:0] rdValue;
    logic wrEn;
    logic regHit;
    logic [1:0] regIdx;
    logic [7:0] wrByte;

    assign wrByte = wbReq.dat[7:0];
    assign pullupEn = pullupEn_q;

    // ----------------------------------------------------------------
    // Bus slave
    // ----------------------------------------------------------------
    ppfm_wb_slave u_wb (
        .sys_clk(sys_clk),
        .reset(reset),
        .wbReq(wbReq),
        .rdValue(rdValue),
        .wbAck(wbAck),
        .wbDatOut(wbDatOut),
        .wrEn(wrEn),
        .regHit(regHit),
        .regIdx(regIdx)
    );

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    // Function select, read/write
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            funcSel_q <= RST_FUNC_SEL;
        end else if (wrEn && regIdx == IDX_FUNC_SEL) begin
            funcSel_q <= wrByte;
        end
    end

    // Direction, write only
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            direction_q <= RST_DIRECTION;
        end else if (wrEn && regIdx == IDX_DIRECTION) begin
            direction_q <= wrByte;
        end
    end

    // Output data latch; output pins read back the latch, input pins their level
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            dataLatch_q <= RST_DATA_LATCH;
        end else if (wrEn && regIdx == IDX_DATA_LATCH) begin
            dataLatch_q <= wrByte;
        end
    end

    // Pull-up control
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            pullup_q <= RST_PULLUP;
        end else if (wrEn && regIdx == IDX_PULLUP) begin
            pullup_q <= wrByte;
        end
    end

    // Pull-up follows direction only, even for alternate functions
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            pullupEn_q <= 8'h00;
        end else begin
            pullupEn_q <= pullup_q & ~direction_q;
        end
    end

    // ----------------------------------------------------------------
    // Read back
    // ----------------------------------------------------------------
    // Input pins show the level, output pins the latch
    assign portRead = (direction_q & dataLatch_q) |
                      (~direction_q & generalPortPinIn);

    // Unmapped addresses answer with zero
    always_comb begin
        rdValue = 32'h0;
        if (regHit) begin
            case (regIdx)
                IDX_DATA_LATCH: rdValue = {24'h0, portRead};
                IDX_DIRECTION: rdValue = {24'h0, DIR_READ_VALUE};
                IDX_PULLUP: rdValue = {24'h0, pullup_q};
                IDX_FUNC_SEL: rdValue = {24'h0, funcSel_q};
                default: rdValue = 32'h0;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Peripheral drive per pin
    // ----------------------------------------------------------------
    // Input-only functions never drive their pin
    always_comb begin
        altOut = 8'h00;
        altOe = 8'h00;
        altOut[BIT_STROBE] = strobeOutput;
        altOe[BIT_STROBE] = 1'b1;
        altOut[BIT_SB_DOUT] = serialBDataOut;
        altOe[BIT_SB_DOUT] = 1'b1;
        altOut[BIT_SB_CLK] = serialBClockOut;
        altOe[BIT_SB_CLK] =
            (serialBClockSourceField != SB_CLK_EXTERNAL);
        altOut[BIT_SA_DOUT] = serialADataOut;
        altOe[BIT_SA_DOUT] = 1'b1;
        altOut[BIT_SA_CLK] = serialAClockOut;
        altOe[BIT_SA_CLK] = ~serialAClockExternal;
    end

    ppfm_pinsel u_pins (
        .sys_clk(sys_clk),
        .reset(reset),
        .funcSel(funcSel_q),
        .direction(direction_q),
        .dataLatch(dataLatch_q),
        .altOut(altOut),
        .altOe(altOe),
        .pinIn(generalPortPinIn),
        .pinOut(generalPortPinOut),
        .pinOe(generalPortPinOe),
        .altIn(altIn)
    );

    // Unselected inputs idle high so peripherals see no activity
    assign chipSelectInN = altIn[BIT_CHIP_SEL];
    assign serialBDataIn = altIn[BIT_SB_DIN];
    assign serialBClockIn = altIn[BIT_SB_CLK];
    assign serialADataIn = altIn[BIT_SA_DIN];
    assign serialAClockIn = altIn[BIT_SA_CLK];

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);

    logic rdAck;
    assign rdAck = wbAck & wbReq.cyc & wbReq.stb & ~wbReq.we & regHit;

    AST_FSEL_READ: assert property (
        rdAck && regIdx == IDX_FUNC_SEL |->
            wbDatOut == {24'h0, funcSel_q})
        else $error("function select readback wrong");

    AST_FSEL_WRITE: assert property (
        wrEn && regIdx == IDX_FUNC_SEL |=> funcSel_q == $past(wrByte))
        else $error("function select write lost");

    AST_CS_IN: assert property (
        funcSel_q[BIT_CHIP_SEL] |=> !generalPortPinOe[BIT_CHIP_SEL] &&
            chipSelectInN == $past(generalPortPinIn[BIT_CHIP_SEL]))
        else $error("chip select pin not routed as input");

    AST_STROBE: assert property (
        funcSel_q[BIT_STROBE] |=> generalPortPinOe[BIT_STROBE] &&
            generalPortPinOut[BIT_STROBE] == $past(strobeOutput))
        else $error("strobe pin not driven");

    AST_SB_DOUT: assert property (
        funcSel_q[BIT_SB_DOUT] |=> generalPortPinOe[BIT_SB_DOUT] &&
            generalPortPinOut[BIT_SB_DOUT] == $past(serialBDataOut))
        else $error("serial B data out not driven");

    AST_SB_DIN: assert property (
        funcSel_q[BIT_SB_DIN] |=> !generalPortPinOe[BIT_SB_DIN] &&
            serialBDataIn == $past(generalPortPinIn[BIT_SB_DIN]))
        else $error("serial B data in not routed");

    AST_SB_CLK: assert property (
        funcSel_q[BIT_SB_CLK] |=> generalPortPinOe[BIT_SB_CLK] ==
            ($past(serialBClockSourceField) != SB_CLK_EXTERNAL))
        else $error("serial B clock direction wrong");

    AST_SA_DOUT: assert property (
        funcSel_q[BIT_SA_DOUT] |=> generalPortPinOe[BIT_SA_DOUT] &&
            generalPortPinOut[BIT_SA_DOUT] == $past(serialADataOut))
        else $error("serial A data out not driven");

    AST_SA_DIN: assert property (
        funcSel_q[BIT_SA_DIN] |=> !generalPortPinOe[BIT_SA_DIN] &&
            serialADataIn == $past(generalPortPinIn[BIT_SA_DIN]))
        else $error("serial A data in not routed");

    AST_SA_CLK: assert property (
        funcSel_q[BIT_SA_CLK] |=> generalPortPinOe[BIT_SA_CLK] ==
            !$past(serialAClockExternal))
        else $error("serial A clock direction wrong");

    AST_GPIO_DIR: assert property (
        1'b1 |=> ((generalPortPinOe ^ $past(direction_q)) &
            ~$past(funcSel_q)) == 8'h00)
        else $error("general pin enable differs from direction");

    AST_ALT_OE: assert property (
        1'b1 |=> ((generalPortPinOe ^ $past(altOe)) &
            $past(funcSel_q)) == 8'h00)
        else $error("selected pin enable not from peripheral");

    // Pin levels checked bit-wise so a swapped route shows at once
    AST_GPIO_OUT: assert property (
        1'b1 |=> ((generalPortPinOut ^ $past(dataLatch_q)) &
            ~$past(funcSel_q)) == 8'h00)
        else $error("general pin level differs from latch");

    AST_ALT_OUT: assert property (
        1'b1 |=> ((generalPortPinOut ^ $past(altOut)) &
            $past(funcSel_q)) == 8'h00)
        else $error("selected pin level not from peripheral");

    AST_ALT_IN: assert property (
        1'b1 |=> ((altIn ^ $past(generalPortPinIn)) &
            $past(funcSel_q)) == 8'h00)
        else $error("peripheral input not from pin level");

    AST_DIR_READ: assert property (
        rdAck && regIdx == IDX_DIRECTION |-> wbDatOut == 32'h0000_00ff)
        else $error("direction readback not all ones");

    AST_DATA_READ: assert property (
        wbReq.cyc && wbReq.stb && !wbReq.we && !wbAck && regHit &&
            regIdx == IDX_DATA_LATCH |=> wbDatOut[7:0] ==
            (($past(direction_q) & $past(dataLatch_q)) |
             (~$past(direction_q) & $past(generalPortPinIn))))
        else $error("port data readback wrong");

    AST_PULLUP: assert property (
        1'b1 |=> pullupEn == ($past(pullup_q) & ~$past(direction_q)))
        else $error("pull-up enable wrong");

    AST_ALT_IDLE: assert property (
        1'b1 |=> (altIn | $past(funcSel_q)) == 8'hff)
        else $error("unselected peripheral input not idle");

    AST_ACK_PULSE: assert property (
        wbReq.cyc && wbReq.stb && !wbAck |=> wbAck ##1 !wbAck)
        else $error("ack not a single cycle after one wait");

    // ----------------------------------------------------------------
    // Covers
    // ----------------------------------------------------------------
    COV_ALL_ALT: cover property (funcSel_q == 8'hff);
    COV_SB_EXT: cover property (
        funcSel_q[BIT_SB_CLK] &&
        serialBClockSourceField == SB_CLK_EXTERNAL);
    COV_WRITE: cover property (wrEn ##2 rdAck);
    COV_MIXED: cover property (
        (direction_q != 8'h00) && (direction_q != 8'hff) && rdAck);

endmodule // ppfm_top

/* hw/ppfm_wb_slave.sv */
// Classic Wishbone slave handshake for the pin multiplexer registers.
// Assumes the master holds a request steady until it sees ack.
`timescale 1ns/1ps
module ppfm_wb_slave import ppfm_pkg::*; (
    input wire logic sys_clk, // System clock
    input wire logic reset, // Async reset, active high
    input wire ppfm_wb_req_s wbReq, // Bus request
    input wire logic [31:0] rdValue, // Read value of addressed word
    output logic wbAck, // Bus acknowledge
    output logic [31:0] wbDatOut, // Registered read data
    output logic wrEn, // Write takes effect this edge
    output logic regHit, // Address maps to a register
    output logic [1:0] regIdx // Addressed register index
);

    logic ack_q;
    logic [31:0] dat_q;
    logic req;

    // Decode: upper address bits must be zero, low two bits ignored
    assign req = wbReq.cyc & wbReq.stb;
    assign regHit = (wbReq.adr[7:4] == 4'h0);
    assign regIdx = wbReq.adr[3:2];
    // Only the low byte lane carries register bits
    assign wrEn = req & ack_q & wbReq.we & regHit & wbReq.sel[0];
    assign wbAck = ack_q;
    assign wbDatOut = dat_q;

    // One wait state; ack drops the cycle after it is given
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= req & ~ack_q;
        end
    end

    // Read data captured on the edge that raises ack
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            dat_q <= 32'h0;
        end else if (req & ~ack_q & ~wbReq.we) begin
            dat_q <= rdValue;
        end
    end

endmodule // ppfm_wb_slave

/* sim/port3_pin_function_mux_tb_top.sv */
// Self-checking bench for the port 3 pin function multiplexer.
// Assumes the design package and ppfm_periph_model are compiled first.
`timescale 1ns/1ps
module port3_pin_function_mux_tb_top import ppfm_pkg::*; ;
    // ------------------------------------------------------------
    // Signals and instances
    // ------------------------------------------------------------
    logic sys_clk = 1'b0;
    logic reset = 1'b1;
    ppfm_wb_req_s wbReq = '0;
    logic wbAck, chipSelectInN, strobeOutput, serialBDataOut;
    logic serialBDataIn, serialBClockOut, serialBClockIn;
    logic serialADataOut, serialADataIn, serialAClockOut, serialAClockIn;
    logic [31:0] wbDatOut, rdv;
    logic [7:0] pinIn = 8'h00;
    logic [7:0] pinOut, pinOe, pullupEn, periphVec, prev;
    logic [4:0] altInVec;
    logic [2:0] clkSrc = 3'h0;
    logic aExt = 1'b0;
    int err_count = 0;
    int comparisons = 0;
    int cycles = 0;

    // Peripheral output levels laid out by pin number
    assign periphVec = {1'b0, strobeOutput, serialBDataOut, 1'b0,
        serialBClockOut, serialADataOut, 1'b0, serialAClockOut};
    // Peripheral input levels, pins 7, 4, 3, 1, 0
    assign altInVec = {chipSelectInN, serialBDataIn, serialBClockIn,
        serialADataIn, serialAClockIn};

    ppfm_top dut_u (.sys_clk(sys_clk), .reset(reset), .wbReq(wbReq),
        .wbAck(wbAck), .wbDatOut(wbDatOut), .generalPortPinIn(pinIn),
        .generalPortPinOut(pinOut), .generalPortPinOe(pinOe),
        .pullupEn(pullupEn), .chipSelectInN(chipSelectInN),
        .strobeOutput(strobeOutput), .serialBDataOut(serialBDataOut),
        .serialBDataIn(serialBDataIn), .serialBClockOut(serialBClockOut),
        .serialBClockIn(serialBClockIn),
        .serialBClockSourceField(clkSrc),
        .serialADataOut(serialADataOut), .serialADataIn(serialADataIn),
        .serialAClockOut(serialAClockOut), .serialAClockIn(serialAClockIn),
        .serialAClockExternal(aExt));

    ppfm_periph_model periph_u (.sys_clk(sys_clk), .reset(reset),
        .strobeOutput(strobeOutput), .serialBDataOut(serialBDataOut),
        .serialBClockOut(serialBClockOut), .serialADataOut(serialADataOut),
        .serialAClockOut(serialAClockOut));

    // 40 MHz clock and a cycle ceiling well above the run length
    always #12.5 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles > 5000) begin
            err_count++;
            end_sim();
        end
    end

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic end_sim();
        $display("Counts: %0d compares, %0d mismatches", comparisons,
            err_count);
        if (err_count == 0 && comparisons > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // One classic cycle, entered just after a rising edge
    // No local limit: only the cycle ceiling ends a hung wait
    task automatic wb(input logic we, input logic [7:0] adr,
        input logic [7:0] wd, output logic [31:0] rd);
        wbReq <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'hf,
            dat: {24'h000000, wd}};
        @(posedge sys_clk);
        while (wbAck !== 1'b1) begin
            @(posedge sys_clk);
        end
        rd = wbDatOut;
        wbReq <= '0;
        @(posedge sys_clk);
    endtask

    // Registered pins need a few edges after a setting changes
    task automatic settle();
        repeat (3) @(posedge sys_clk);
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        wb(1'b0, OFS_FUNC_SEL, 8'h00, rdv);
        chk(rdv, 32'h00000000);
        wb(1'b0, OFS_DIRECTION, 8'h00, rdv);
        chk(rdv, 32'h000000ff);
        wb(1'b0, 8'h10, 8'h00, rdv);
        chk(rdv, 32'h00000000);
        chk(pinOe, 8'h00);
        $display("test reset done");
    endtask

    task automatic t_fsel_rw();
        wb(1'b1, OFS_FUNC_SEL, 8'ha5, rdv);
        wb(1'b0, OFS_FUNC_SEL, 8'h00, rdv);
        chk(rdv, 32'h000000a5);
        wb(1'b1, OFS_FUNC_SEL, 8'h5a, rdv);
        wb(1'b1, 8'h1c, 8'hff, rdv);
        wb(1'b0, OFS_FUNC_SEL, 8'h00, rdv);
        chk(rdv, 32'h0000005a);
        $display("test select read/write done");
    endtask

    task automatic t_gpio();
        wb(1'b1, OFS_FUNC_SEL, 8'h00, rdv);
        wb(1'b1, OFS_DIRECTION, 8'hf0, rdv);
        wb(1'b1, OFS_DATA_LATCH, 8'h3c, rdv);
        wb(1'b1, OFS_PULLUP, 8'h33, rdv);
        pinIn <= 8'h96;
        settle();
        chk(pinOe, 8'hf0);
        chk(pinOut & 8'hf0, 8'h30);
        chk(pullupEn, 8'h03);
        chk(altInVec, 5'h1f);
        wb(1'b0, OFS_PULLUP, 8'h00, rdv);
        chk(rdv, 32'h00000033);
        wb(1'b0, OFS_DATA_LATCH, 8'h00, rdv);
        chk(rdv, 32'h00000036);
        wb(1'b0, OFS_DIRECTION, 8'h00, rdv);
        chk(rdv, 32'h000000ff);
        $display("test general io done");
    endtask

    // One select bit at a time, direction all in, must own one pin
    task automatic t_single();
        logic [7:0] m;
        wb(1'b1, OFS_DIRECTION, 8'h00, rdv);
        for (int i = 0; i < 8; i++) begin
            m = 8'h01 << i;
            wb(1'b1, OFS_FUNC_SEL, m, rdv);
            settle();
            chk(pinOe & 8'h0f, m & 8'h0d);
            chk(pinOe & 8'hf0, m & 8'h60);
        end
        $display("test single select done");
    endtask

    task automatic t_alt();
        logic [7:0] pv [3];
        logic [4:0] ex;
        pv = '{8'h00, 8'hff, 8'h5a};
        wb(1'b1, OFS_DIRECTION, 8'hff, rdv);
        wb(1'b1, OFS_DATA_LATCH, 8'h00, rdv);
        wb(1'b1, OFS_FUNC_SEL, 8'hff, rdv);
        settle();
        chk(pinOe, 8'h6d);
        for (int k = 0; k < 4; k++) begin
            prev = periphVec;
            @(posedge sys_clk);
            chk(pinOut & 8'h6d, prev & 8'h6d);
        end
        clkSrc <= SB_CLK_EXTERNAL;
        aExt <= 1'b1;
        settle();
        chk(pinOe, 8'h64);
        for (int k = 0; k < 3; k++) begin
            pinIn <= pv[k];
            settle();
            ex = {pv[k][7], pv[k][4:3], pv[k][1:0]};
            chk(altInVec, ex);
        end
        // Only the full code 111 turns the B clock pin around
        clkSrc <= 3'h6;
        settle();
        chk(pinOe, 8'h6c);
        $display("test alternate functions done");
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (5) @(posedge sys_clk);
        reset <= 1'b0;
        @(posedge sys_clk);
        t_reset();
        t_fsel_rw();
        t_gpio();
        t_single();
        t_alt();
        end_sim();
    end
endmodule // port3_pin_function_mux_tb_top

/* sim/ppfm_periph_model.sv */
// Behavioural model of the serial units and strobe source beside port 3.
// Assumes it shares sys_clk and reset with the pin multiplexer.
`timescale 1ns/1ps
module ppfm_periph_model (
    input wire logic sys_clk, // System clock
    input wire logic reset, // Async reset, active high
    output logic strobeOutput, // Strobe level
    output logic serialBDataOut, // Serial B transmit data
    output logic serialBClockOut, // Serial B internal clock
    output logic serialADataOut, // Serial A transmit data
    output logic serialAClockOut // Serial A internal clock
);
    logic [4:0] patQ;

    // Odd step keeps every level moving, so a stale route shows up
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            patQ <= 5'h00;
        end else begin
            patQ <= patQ + 5'h0b;
        end
    end

    // Levels offered to the alternate output pins
    assign {strobeOutput, serialBDataOut, serialBClockOut} = patQ[4:2];
    assign {serialADataOut, serialAClockOut} = patQ[1:0];
endmodule // ppfm_periph_model
